// file: shared/diag_led_pkg.sv
// Constants shared by the diagnostic lamp logic
package diag_led_pkg;
	localparam int unsigned CHAN_N          = 8;
	localparam int unsigned CHAN_W          = 3;
	localparam longint      CLK_HZ          = 64'h0000_0000_02FA_F080;
	// Host link silence that counts as lost communication
	localparam longint      COMM_TIMEOUT_MS = 64'h0000_0000_0000_0064;
	localparam int unsigned COMM_TIMEOUT_CYC =
		int'((COMM_TIMEOUT_MS * CLK_HZ) / 64'h0000_0000_0000_03E8);
	// Longest gap between end-of-conversion edges while field power is good
	localparam longint      EOC_TIMEOUT_MS  = 64'h0000_0000_0000_0014;
	localparam int unsigned EOC_TIMEOUT_CYC =
		int'((EOC_TIMEOUT_MS * CLK_HZ) / 64'h0000_0000_0000_03E8);
	localparam int unsigned WD_W            = 23;
	localparam logic [1:0]  HART_RETRIES    = 2'h3;
	localparam logic [7:0]  NO_REPLY_MASK   = 8'hFF;
	localparam logic [7:0]  CHAN_LED_RST    = 8'h00;
	localparam logic [1:0]  RETRY_CNT_RST   = 2'h0;

	typedef enum logic [2:0] {
		DISP_IDLE = 3'b001,
		DISP_WAIT = 3'b010,
		DISP_FAIL = 3'b100
	} disp_state_e;
endpackage

// file: rtl/activity_watchdog.sv
// Retriggerable watchdog: alive while kicks arrive within the limit
`timescale 1ns/1ns
`default_nettype none
module activity_watchdog #(
	parameter int unsigned LIMIT = 1000
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic kick,
	output var  logic alive
);
	logic [diag_led_pkg::WD_W-1:0] cnt_q;
	logic [diag_led_pkg::WD_W-1:0] cnt_d;
	logic                          alive_q;
	logic                          alive_d;

	always_comb begin
		cnt_d   = cnt_q;
		alive_d = alive_q;
		if (kick) begin
			cnt_d   = '0;
			alive_d = 1'b1;
		end else if (alive_q) begin
			if (cnt_q == diag_led_pkg::WD_W'(LIMIT - 1)) begin
				alive_d = 1'b0;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_q   <= '0;
			alive_q <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			alive_q <= alive_d;
		end
	end

	assign alive = alive_q;
endmodule
`default_nettype wire

// file: rtl/hart_retry_tracker.sv
// Counts failed HART attempts and flags when all retries are spent
`timescale 1ns/1ns
`default_nettype none
module hart_retry_tracker (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic clear,
	input  wire logic first_req,
	input  wire logic attempt_fail,
	output var  logic give_up
);
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic       give_up_q;
	logic       give_up_d;

	always_comb begin
		cnt_d     = cnt_q;
		give_up_d = 1'b0;
		if (clear || first_req) begin
			cnt_d = diag_led_pkg::RETRY_CNT_RST;
		end else if (attempt_fail) begin
			if (cnt_q == diag_led_pkg::HART_RETRIES) begin
				give_up_d = 1'b1;
				cnt_d     = diag_led_pkg::RETRY_CNT_RST;
			end else begin
				cnt_d = cnt_q + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_q     <= diag_led_pkg::RETRY_CNT_RST;
			give_up_q <= 1'b0;
		end else begin
			cnt_q     <= cnt_d;
			give_up_q <= give_up_d;
		end
	end

	assign give_up = give_up_q;
endmodule
`default_nettype wire

// file: rtl/diag_led_status_logic.sv
// Front-panel diagnostic lamp logic of an eight-channel HART I/O module
`timescale 1ns/1ns
`default_nettype none
module diag_led_status_logic #(
	parameter int unsigned COMM_TIMEOUT = diag_led_pkg::COMM_TIMEOUT_CYC,
	parameter int unsigned EOC_TIMEOUT  = diag_led_pkg::EOC_TIMEOUT_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       supply_ok,
	input  wire logic       host_access,
	input  wire logic       eoc_in,
	input  wire logic       ref_out_of_range,
	input  wire logic       flash_test_fail,
	input  wire logic       ee_test_fail,
	input  wire logic       ram_test_fail,
	input  wire logic       cfg_wr,
	input  wire logic       cfg_wr_configure,
	input  wire logic       cfg_wr_force,
	input  wire logic       hart_req,
	input  wire logic       hart_req_retry,
	input  wire logic [2:0] hart_chan,
	input  wire logic       hart_reply_ok,
	input  wire logic       hart_attempt_fail,
	output var  logic       led_power,
	output var  logic       led_link,
	output var  logic       led_ext_fault,
	output var  logic       led_int_fault,
	output var  logic [7:0] chan_led,
	output var  logic       cfg_configured,
	output var  logic       cfg_forced
);
	////////////////////////////////////////////////////////////////////////////
	// Watchdogs on host link and converter strobe

	logic link_alive;
	logic eoc_alive;
	logic eoc_prev_q;
	logic eoc_edge;

	assign eoc_edge = eoc_in ^ eoc_prev_q;

	activity_watchdog #(
		.LIMIT (COMM_TIMEOUT)
	) u_link_wd (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.kick    (host_access),
		.alive   (link_alive)
	);

	activity_watchdog #(
		.LIMIT (EOC_TIMEOUT)
	) u_eoc_wd (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.kick    (eoc_edge),
		.alive   (eoc_alive)
	);

	////////////////////////////////////////////////////////////////////////////
	// Configuration bits and status lamps

	logic       configured_q;
	logic       configured_d;
	logic       forced_q;
	logic       forced_d;
	logic       link_seen_q;
	logic       link_seen_d;
	logic       comm_lost;
	logic       led_power_q;
	logic       led_link_q;
	logic       led_ext_q;
	logic       led_int_q;
	logic       led_int_d;

	// Lost only counts once the host has talked at least once
	assign comm_lost = link_seen_q && !link_alive;

	always_comb begin
		configured_d = configured_q;
		forced_d     = forced_q;
		link_seen_d  = link_seen_q | host_access;
		if (cfg_wr) begin
			configured_d = cfg_wr_configure;
			forced_d     = cfg_wr_force;
		end
		// field power loss stays off this lamp
		led_int_d = forced_q | comm_lost | ref_out_of_range
			| flash_test_fail | ee_test_fail | ram_test_fail;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			configured_q <= 1'b0;
			forced_q     <= 1'b0;
			link_seen_q  <= 1'b0;
			eoc_prev_q   <= 1'b0;
			led_power_q  <= 1'b0;
			led_link_q   <= 1'b0;
			led_ext_q    <= 1'b0;
			led_int_q    <= 1'b0;
		end else begin
			configured_q <= configured_d;
			forced_q     <= forced_d;
			link_seen_q  <= link_seen_d;
			eoc_prev_q   <= eoc_in;
			led_power_q  <= supply_ok;
			led_link_q   <= link_alive;
			// no strobe edges means field power gone
			led_ext_q    <= !eoc_alive;
			led_int_q    <= led_int_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel traffic display

	logic [7:0]                      chan_led_q;
	logic [7:0]                      chan_led_d;
	logic [diag_led_pkg::CHAN_W-1:0] chan_sel_q;
	logic [diag_led_pkg::CHAN_W-1:0] chan_sel_d;
	diag_led_pkg::disp_state_e       disp_q;
	diag_led_pkg::disp_state_e       disp_d;
	logic [7:0]                      req_onehot;
	logic [7:0]                      sel_onehot;
	logic                            first_req;
	logic                            attempt_fail;
	logic                            tracker_clear;
	logic                            give_up;

	assign req_onehot    = 8'h01 << hart_chan;
	assign sel_onehot    = 8'h01 << chan_sel_q;

	assign first_req     = configured_q && hart_req && !hart_req_retry;
	// Silence only counts against a request still waiting
	assign attempt_fail  = configured_q && hart_attempt_fail
		&& (disp_q == diag_led_pkg::DISP_WAIT);
	// Good reply or deconfiguration forgets old failures
	assign tracker_clear = !configured_q || hart_reply_ok;

	hart_retry_tracker u_retry (
		.clk_sys      (clk_sys),
		.sys_rst      (sys_rst),
		.clear        (tracker_clear),
		.first_req    (first_req),
		.attempt_fail (attempt_fail),
		.give_up      (give_up)
	);

	always_comb begin
		disp_d     = disp_q;
		chan_sel_d = chan_sel_q;
		chan_led_d = chan_led_q;
		if (!configured_q) begin
			disp_d     = diag_led_pkg::DISP_IDLE;
			chan_led_d = diag_led_pkg::CHAN_LED_RST;
		end else if (hart_req) begin
			disp_d     = diag_led_pkg::DISP_WAIT;
			chan_sel_d = hart_chan;
			chan_led_d = req_onehot;
		end else begin
			unique case (disp_q)
				diag_led_pkg::DISP_IDLE: begin
					chan_led_d = chan_led_q;
				end
				diag_led_pkg::DISP_WAIT: begin
					if (hart_reply_ok) begin
						disp_d     = diag_led_pkg::DISP_IDLE;
						chan_led_d = diag_led_pkg::CHAN_LED_RST;
					end else if (give_up) begin
						disp_d     = diag_led_pkg::DISP_FAIL;
						chan_led_d = sel_onehot ^ diag_led_pkg::NO_REPLY_MASK;
					end
				end
				diag_led_pkg::DISP_FAIL: begin
					// Pattern holds until the next request
					chan_led_d = chan_led_q;
				end
				default: begin
					disp_d     = diag_led_pkg::DISP_IDLE;
					chan_led_d = diag_led_pkg::CHAN_LED_RST;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			disp_q     <= diag_led_pkg::DISP_IDLE;
			chan_sel_q <= '0;
			chan_led_q <= diag_led_pkg::CHAN_LED_RST;
		end else begin
			disp_q     <= disp_d;
			chan_sel_q <= chan_sel_d;
			chan_led_q <= chan_led_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops

	assign led_power      = led_power_q;
	assign led_link       = led_link_q;
	assign led_ext_fault  = led_ext_q;
	assign led_int_fault  = led_int_q;
	assign chan_led       = chan_led_q;
	assign cfg_configured = configured_q;
	assign cfg_forced     = forced_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_power_follows: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		!$past(sys_rst) |-> (led_power == $past(supply_ok))
	) else $error("power lamp does not follow supply flag");

	a_int_forced: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		!$past(sys_rst) && $past(forced_q) |-> led_int_fault
	) else $error("forced fault not shown on internal lamp");

	a_int_comm_lost: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		!$past(sys_rst) && $past(comm_lost) |-> led_int_fault
	) else $error("lost host link not shown on internal lamp");

	a_int_selftest: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		!$past(sys_rst) && $past(ref_out_of_range || flash_test_fail
			|| ee_test_fail || ram_test_fail) |-> led_int_fault
	) else $error("self-test fault not shown on internal lamp");

	// field loss stays off internal lamp
	a_int_quiet: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		!$past(sys_rst) && !$past(forced_q || comm_lost || ref_out_of_range
			|| flash_test_fail || ee_test_fail || ram_test_fail) |-> !led_int_fault
	) else $error("internal lamp lit without internal cause");

	a_chan_dark: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		!configured_q |=> (chan_led == diag_led_pkg::CHAN_LED_RST)
	) else $error("channel lamps lit while unconfigured");

	a_req_lights: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		configured_q && hart_req |=> (chan_led == (8'h01 << $past(hart_chan)))
	) else $error("request did not light its channel lamp alone");

	a_reply_clears: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		configured_q && !hart_req && hart_reply_ok
			&& (disp_q == diag_led_pkg::DISP_WAIT)
		|=> (chan_led == diag_led_pkg::CHAN_LED_RST)
	) else $error("good reply did not clear channel lamp");

	a_no_reply_mask: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		configured_q && !hart_req && !hart_reply_ok && give_up
			&& (disp_q == diag_led_pkg::DISP_WAIT)
		|=> (chan_led == ((8'h01 << $past(chan_sel_q)) ^ diag_led_pkg::NO_REPLY_MASK))
	) else $error("no-reply pattern wrong");

	// no failure display before retries spent
	a_no_early_fail: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		(disp_q != diag_led_pkg::DISP_FAIL) && !give_up
		|=> (disp_q != diag_led_pkg::DISP_FAIL)
	) else $error("no-reply display before retries spent");

	a_reset_dark: assert property (
		@(posedge clk_sys)
		sys_rst |=> (chan_led == diag_led_pkg::CHAN_LED_RST) && !led_power
			&& !led_int_fault && !led_link
	) else $error("lamps not dark after reset");

	// Normal blink seen
	c_blink: cover property (
		@(posedge clk_sys) disable iff (sys_rst)
		(disp_q == diag_led_pkg::DISP_WAIT) && hart_reply_ok
	);

	// Retries exhausted
	c_no_reply: cover property (
		@(posedge clk_sys) disable iff (sys_rst)
		disp_q == diag_led_pkg::DISP_FAIL
	);

	// Host link lost
	c_comm_lost: cover property (
		@(posedge clk_sys) disable iff (sys_rst)
		comm_lost
	);

	// Field power lost
	c_field_loss: cover property (
		@(posedge clk_sys) disable iff (sys_rst)
		led_ext_fault && led_power
	);
endmodule
`default_nettype wire

// file: bench/hart_field_model.sv
// Field device stand-in answering HART requests
`timescale 1ns/1ns
`default_nettype none
module hart_field_model (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       hart_req,
	input  wire logic [2:0] hart_chan,
	input  wire logic [7:0] present,
	output var  logic       hart_reply_ok,
	output var  logic       hart_attempt_fail
);
	logic [2:0] dly_q;
	logic       hit_q;
	always_ff @(posedge clk_sys) begin
		hart_reply_ok <= 1'b0;
		hart_attempt_fail <= 1'b0;
		if (sys_rst) begin
			dly_q <= 3'h0;
		end else if (hart_req) begin
			dly_q <= 3'h4;
			hit_q <= present[hart_chan];
		end else if (dly_q != 3'h0) begin
			dly_q <= dly_q - 3'h1;
			if (dly_q == 3'h1) begin
				hart_reply_ok <= hit_q;
				hart_attempt_fail <= !hit_q;
			end
		end
	end
endmodule
`default_nettype wire

// file: bench/diag_led_status_logic_test.sv
// Self-checking bench for the diagnostic lamp logic
`timescale 1ns/1ns
`default_nettype none
module diag_led_status_logic_test;
	logic clk_sys = 0, sys_rst = 1, supply_ok = 0, host_access = 0, eoc_in = 0;
	logic cfg_wr = 0, cfg_wr_configure = 0, cfg_wr_force = 0, hart_req = 0, hart_req_retry = 0;
	logic kick_en = 0, eoc_en = 0, ok, fl, pw, lk, ef, itf, cc, cf;
	logic [3:0] flt = 4'h0;
	logic [2:0] hart_chan = 3'h0, tick = 3'h0;
	logic [7:0] cl;
	int err_count = 0, checked = 0;
	diag_led_status_logic #(.COMM_TIMEOUT(50), .EOC_TIMEOUT(40)) diag_led_status_logic_i (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .supply_ok(supply_ok),
		.host_access(host_access), .eoc_in(eoc_in), .ref_out_of_range(flt[0]),
		.flash_test_fail(flt[1]), .ee_test_fail(flt[2]), .ram_test_fail(flt[3]),
		.cfg_wr(cfg_wr), .cfg_wr_configure(cfg_wr_configure), .cfg_wr_force(cfg_wr_force),
		.hart_req(hart_req), .hart_req_retry(hart_req_retry), .hart_chan(hart_chan),
		.hart_reply_ok(ok), .hart_attempt_fail(fl), .led_power(pw), .led_link(lk),
		.led_ext_fault(ef), .led_int_fault(itf), .chan_led(cl), .cfg_configured(cc),
		.cfg_forced(cf));
	hart_field_model hart_field_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.hart_req(hart_req), .hart_chan(hart_chan), .present(8'h20),
		.hart_reply_ok(ok), .hart_attempt_fail(fl));
	initial forever #10 clk_sys = ~clk_sys;
	// Host polls every eighth cycle, converter strobe toggles every cycle
	always @(posedge clk_sys) begin
		tick <= tick + 3'h1;
		host_access <= kick_en && tick == 3'h0;
		eoc_in <= eoc_en ? ~eoc_in : eoc_in;
	end
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task cfg(input logic c, input logic f);
		@(posedge clk_sys);
		cfg_wr <= 1'b1;
		cfg_wr_configure <= c;
		cfg_wr_force <= f;
		cyc(1);
		cfg_wr <= 1'b0;
		cyc(3);
	endtask
	// One attempt; lamp looked at while the answer is pending, on first requests only (not retries)
	task hart(input logic [2:0] ch, input logic rt, input logic [7:0] e);
		int i;
		@(posedge clk_sys);
		hart_req <= 1'b1;
		hart_chan <= ch;
		hart_req_retry <= rt;
		cyc(1);
		hart_req <= 1'b0;
		hart_req_retry <= 1'b0;
		cyc(2);
		if (!rt) chk("chan_led", cl, e);
		for (i = 0; i < 10 && ok !== 1'b1 && fl !== 1'b1; i++) cyc(1);
		cyc(3);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#400000;
		err_count++;
		summarize();
	end
	initial begin
		cyc(6);
		sys_rst <= 1'b0;
		cyc(2);
		chk("chan_led", cl, 8'h00);
		chk("cfg_configured", cc, 1'b0);
		supply_ok <= 1'b1;
		kick_en <= 1'b1;
		eoc_en <= 1'b1;
		cyc(60);
		chk("led_power", pw, 1'b1);
		chk("led_link", lk, 1'b1);
		chk("led_ext_fault", ef, 1'b0);
		chk("led_int_fault", itf, 1'b0);
		for (int i = 0; i < 4; i++) begin
			flt <= 4'h1 << i;
			cyc(4);
			chk("led_int_fault", itf, 1'b1);
			flt <= 4'h0;
			cyc(4);
		end
		eoc_en <= 1'b0;
		cyc(60);
		chk("led_ext_fault", ef, 1'b1);
		chk("led_int_fault", itf, 1'b0);
		eoc_en <= 1'b1;
		cfg(1'b0, 1'b1);
		chk("cfg_forced", cf, 1'b1);
		chk("led_int_fault", itf, 1'b1);
		cfg(1'b0, 1'b0);
		hart(3'h2, 1'b0, 8'h00);
		cfg(1'b1, 1'b0);
		chk("cfg_configured", cc, 1'b1);
		hart(3'h5, 1'b0, 8'h20);
		chk("chan_led", cl, 8'h00);
		hart(3'h2, 1'b0, 8'h04);
		chk("chan_led", cl, 8'h04);
		repeat (3) hart(3'h2, 1'b1, 8'h04);
		chk("chan_led", cl, 8'hFB);
		supply_ok <= 1'b0;
		cyc(2);
		chk("led_power", pw, 1'b0);
		kick_en <= 1'b0;
		cyc(80);
		chk("led_link", lk, 1'b0);
		chk("led_int_fault", itf, 1'b1);
		summarize();
	end
endmodule
`default_nettype wire
